//--- rtl/sram_host_ctl.v
// Purpose: host-side controller for an asynchronous 256K x 16 static memory
// Assumes: one request at a time, taken when req_ready is high
// Notes:   at 50 ns per cycle every memory time fits in one cycle
`timescale 1ns/1ns
`include "sram_ctl_consts.vh"
module sram_host_ctl (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 req_valid,
  input  wire                 req_write,
  input  wire [`ADDR_W-1:0]   req_addr,
  input  wire [1:0]           req_byte_en,
  input  wire [`DATA_W-1:0]   req_wdata,
  output reg                  req_ready,
  output reg                  rsp_valid,
  output reg  [`DATA_W-1:0]   rsp_rdata,
  output wire [`ADDR_W-1:0]   word_address,
  output wire                 chip_select_n,
  output wire                 write_strobe_n,
  output wire                 output_enable_n,
  output wire                 low_byte_enable_n,
  output wire                 high_byte_enable_n,
  input  wire [`DATA_W-1:0]   data_bus_in,
  output wire [`DATA_W-1:0]   data_bus_out,
  output wire                 data_bus_oe
);
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_SETUP  = 3'd1;
  localparam [2:0] ST_ACTIVE = 3'd2;
  localparam [2:0] ST_END    = 3'd3;
  localparam [2:0] ST_HOLD   = 3'd4;
  // rounded counts are 32-bit; cut to the counter width on purpose
  localparam [31:0]       PULSE_CYC_W = `CYC_WRITE_PULSE;
  localparam [31:0]       READ_CYC_W  = `CYC_OE_ACCESS;
  localparam [`CNT_W-1:0] PULSE_CYC   = PULSE_CYC_W[`CNT_W-1:0];
  localparam [`CNT_W-1:0] READ_CYC    = READ_CYC_W[`CNT_W-1:0];

  reg [2:0]         state;
  reg [`CNT_W-1:0]  count;
  reg               op_write;
  reg [`ADDR_W-1:0] op_addr;
  reg [1:0]         op_be;
  reg [`DATA_W-1:0] op_data;
  reg [2:0]         next_state;
  reg [`CNT_W-1:0]  next_count;
  reg               next_cs_n;
  reg               next_we_n;
  reg               next_oe_n;
  reg               next_doe;

  // read data sampled from the pin, the memory answers well inside a cycle
  reg [`DATA_W-1:0] rd_s1;
  reg [`DATA_W-1:0] rd_s2;
  reg [`DATA_W-1:0] rd_s3;

  // merges new read bytes over zero for disabled lanes
  function [`DATA_W-1:0] lane_mask;
    input [1:0]         be;
    input [`DATA_W-1:0] d;
    begin
      lane_mask = d & {{`BYTE_W{be[1]}}, {`BYTE_W{be[0]}}};
    end
  endfunction

  always @* begin
    next_state = state;
    next_count = count;
    next_cs_n  = 1'b1;
    next_we_n  = 1'b1;
    next_oe_n  = 1'b1;
    next_doe   = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_state = ST_SETUP;
        end
      end
      // address reaches the pins on the same edge that select falls
      ST_SETUP: begin
        next_cs_n  = 1'b0;
        next_we_n  = ~op_write;
        next_oe_n  = op_write;
        next_doe   = op_write;
        // at this clock every count rounds to one, so ACTIVE lasts a single cycle
        next_count = op_write ? PULSE_CYC : READ_CYC;
        next_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        next_cs_n = 1'b0;
        next_we_n = ~op_write;
        next_oe_n = op_write;
        next_doe  = op_write;
        if (count <= {{(`CNT_W-1){1'b0}}, 1'b1}) begin
          next_state = ST_END;
        end else begin
          next_count = count - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // strobes rise together; data held one more cycle for hold time
      ST_END: begin
        next_doe   = op_write;
        next_state = ST_HOLD;
      end
      ST_HOLD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      count     <= {`CNT_W{1'b0}};
      op_write  <= 1'b0;
      op_addr   <= {`ADDR_W{1'b0}};
      op_be     <= 2'b00;
      op_data   <= {`DATA_W{1'b0}};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {`DATA_W{1'b0}};
      rd_s1     <= {`DATA_W{1'b0}};
      rd_s2     <= {`DATA_W{1'b0}};
      rd_s3     <= {`DATA_W{1'b0}};
    end else begin
      state     <= next_state;
      count     <= next_count;
      rd_s1     <= data_bus_in;
      rd_s2     <= rd_s1;
      rd_s3     <= rd_s2;
      // ready drops on the taking edge so a request still held is not taken twice
      req_ready <= (next_state == ST_IDLE) && !(req_valid && req_ready);
      rsp_valid <= 1'b0;
      if (state == ST_IDLE && req_valid && req_ready) begin
        op_write <= req_write;
        op_addr  <= req_addr;
        op_be    <= req_byte_en;
        op_data  <= req_wdata;
      end
      // stable when the second and third stages agree; on a short read the third
      // stage may still hold the bus from before select fell, so the second stage
      // is the fallback and is already a full cycle past the access time
      if (state == ST_HOLD) begin
        rsp_valid <= 1'b1;
        if (!op_write && rd_s2 == rd_s3) begin
          rsp_rdata <= lane_mask(op_be, rd_s3);
        end else if (!op_write) begin
          rsp_rdata <= lane_mask(op_be, rd_s2);
        end
      end
    end
  end

  // byte enables follow select, so a deselected memory never sees a stray lane
  sram_pin_drive u_pins (
    .clk                (clk),
    .rst                (rst),
    .next_addr          (op_addr),
    .next_cs_n          (next_cs_n),
    .next_we_n          (next_we_n),
    .next_oe_n          (next_oe_n),
    .next_lbe_n         (~(op_be[0] && next_cs_n == 1'b0)),
    .next_hbe_n         (~(op_be[1] && next_cs_n == 1'b0)),
    .next_dout          (op_data),
    .next_doe           (next_doe),
    .word_address       (word_address),
    .chip_select_n      (chip_select_n),
    .write_strobe_n     (write_strobe_n),
    .output_enable_n    (output_enable_n),
    .low_byte_enable_n  (low_byte_enable_n),
    .high_byte_enable_n (high_byte_enable_n),
    .data_bus_out       (data_bus_out),
    .data_bus_oe        (data_bus_oe)
  );
endmodule // sram_host_ctl

//--- rtl/sram_ctl_consts.vh
// Purpose: constants for the asynchronous word/byte static memory controller
// Assumes: 20 MHz clock, slower speed grade timing throughout
// Notes:   times in ns, cycle counts derived by rounding up
`ifndef SRAM_CTL_CONSTS_VH
`define SRAM_CTL_CONSTS_VH
`define CLK_PERIOD_NS      50
`define ADDR_W             18
`define DATA_W             16
`define BYTE_W             8
`define T_CYCLE_NS         15
`define T_WRITE_PULSE_NS   12
`define T_DATA_SETUP_NS    7
`define T_OE_ACCESS_NS     7
`define T_RELEASE_NS       3
`define CEIL_CYC(t)        (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_CYCLE          `CEIL_CYC(`T_CYCLE_NS)
`define CYC_WRITE_PULSE    `CEIL_CYC(`T_WRITE_PULSE_NS)
`define CYC_OE_ACCESS      `CEIL_CYC(`T_OE_ACCESS_NS)
`define CYC_RELEASE        `CEIL_CYC(`T_RELEASE_NS)
`define CNT_W              3
`endif

//--- rtl/sram_pin_drive.v
// Purpose: registered pin stage for the memory data bus and strobes
// Assumes: the parent presents next values one cycle ahead
// Notes:   every pin output comes straight from a flip-flop
`timescale 1ns/1ns
`include "sram_ctl_consts.vh"
module sram_pin_drive (
  input  wire                 clk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   next_addr,
  input  wire                 next_cs_n,
  input  wire                 next_we_n,
  input  wire                 next_oe_n,
  input  wire                 next_lbe_n,
  input  wire                 next_hbe_n,
  input  wire [`DATA_W-1:0]   next_dout,
  input  wire                 next_doe,
  output reg  [`ADDR_W-1:0]   word_address,
  output reg                  chip_select_n,
  output reg                  write_strobe_n,
  output reg                  output_enable_n,
  output reg                  low_byte_enable_n,
  output reg                  high_byte_enable_n,
  output reg  [`DATA_W-1:0]   data_bus_out,
  output reg                  data_bus_oe
);
  always @(posedge clk) begin
    if (rst) begin
      word_address       <= {`ADDR_W{1'b0}};
      chip_select_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
      output_enable_n    <= 1'b1;
      low_byte_enable_n  <= 1'b1;
      high_byte_enable_n <= 1'b1;
      data_bus_out       <= {`DATA_W{1'b0}};
      data_bus_oe        <= 1'b0;
    end else begin
      word_address       <= next_addr;
      chip_select_n      <= next_cs_n;
      write_strobe_n     <= next_we_n;
      output_enable_n    <= next_oe_n;
      low_byte_enable_n  <= next_lbe_n;
      high_byte_enable_n <= next_hbe_n;
      data_bus_out       <= next_dout;
      data_bus_oe        <= next_doe;
    end
  end
endmodule // sram_pin_drive

//--- sim/sram_ctl_chk_properties.sv
// Purpose: pin timing and answer latency checks on the memory controller
// Assumes: one clock, rst synchronous and active high
// Notes:   bound from tb
`timescale 1ns/1ns
`include "sram_ctl_consts.vh"
module sram_ctl_chk (
  input wire               clk,
  input wire               rst,
  input wire               req_valid,
  input wire               req_ready,
  input wire               rsp_valid,
  input wire [`ADDR_W-1:0] word_address,
  input wire               chip_select_n,
  input wire               write_strobe_n,
  input wire               output_enable_n,
  input wire [`DATA_W-1:0] data_bus_out,
  input wire               data_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_pulse; !write_strobe_n [*2] ##1 write_strobe_n; endsequence
  sequence wr_hold; data_bus_oe ##1 !data_bus_oe; endsequence
  AST_RD_WE_HIGH: assert property (!output_enable_n |-> write_strobe_n)
    else $error("write strobe low in read");
  AST_WR_IN_SEL: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("write strobe low while deselected");
  AST_NO_CLASH: assert property (data_bus_oe |-> output_enable_n)
    else $error("bus driven while memory outputs on");
  AST_ADDR_HOLD: assert property (
    !chip_select_n && $past(!chip_select_n) |-> $stable(word_address))
    else $error("address moved in access");
  AST_WR_WIDTH: assert property ($fell(write_strobe_n) |-> wr_pulse)
    else $error("write pulse width wrong");
  AST_WR_DATA: assert property (
    $fell(write_strobe_n) |-> data_bus_oe ##1 data_bus_oe && $stable(data_bus_out))
    else $error("write data not steady");
  AST_WR_HOLD: assert property ($rose(write_strobe_n) |-> wr_hold)
    else $error("write data hold wrong");
  AST_ANSWER: assert property (req_valid && req_ready |-> ##5 rsp_valid)
    else $error("answer late");
endmodule // sram_ctl_chk

//--- sim/sram_model.sv
// Purpose: behavioural word/byte static memory
// Assumes: pins change on clk edges only
// Notes:   floated lanes show the inverse of the last driven bus value
`timescale 1ns/1ns
`include "sram_ctl_consts.vh"
module sram_model (
  input  wire                clk,
  input  wire [`ADDR_W-1:0]  word_address,
  input  wire                chip_select_n,
  input  wire                write_strobe_n,
  input  wire                output_enable_n,
  input  wire                low_byte_enable_n,
  input  wire                high_byte_enable_n,
  input  wire [`DATA_W-1:0]  data_bus_out,
  input  wire                data_bus_oe,
  output logic [`DATA_W-1:0] data_bus_in
);
  logic [`DATA_W-1:0] mem [0:(1 << `ADDR_W)-1];
  logic [`DATA_W-1:0] q;
  logic [`DATA_W-1:0] last = 16'h0000;
  logic [1:0]         en;
  logic               rd;
  logic               wr_tick = 1'b0;
  assign en = ~{high_byte_enable_n, low_byte_enable_n};
  // outputs only while selected, reading and strobe high
  assign rd = !chip_select_n && !output_enable_n && write_strobe_n;
  initial begin
    for (int i = 0; i < (1 << `ADDR_W); i++)
      mem[i] = 16'h0000;
  end
  // array contents are not in the list, so each write toggles wr_tick instead
  always @(word_address or rd or en or last or data_bus_out or data_bus_oe or wr_tick) begin
    q = mem[word_address];
    data_bus_in[7:0] = (rd && en[0]) ? q[7:0] : ~last[7:0];
    data_bus_in[15:8] = (rd && en[1]) ? q[15:8] : ~last[15:8];
    if (data_bus_oe)
      data_bus_in = data_bus_out;
  end
  always @(posedge clk) begin
    if (data_bus_oe || rd)
      last <= data_bus_in;
    if (!chip_select_n && !write_strobe_n) begin
      mem[word_address] <= {en[1] ? data_bus_out[15:8] : mem[word_address][15:8],
                            en[0] ? data_bus_out[7:0] : mem[word_address][7:0]};
      wr_tick <= ~wr_tick;
    end
  end
endmodule // sram_model

//--- sim/tb.sv
// Purpose: self-checking bench for the memory controller
// Assumes: inputs change on the falling edge
// Notes:   memory model sits on the pins
`timescale 1ns/1ns
`include "sram_ctl_consts.vh"
module tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               req_valid = 1'b0;
  logic               req_write = 1'b0;
  logic [`ADDR_W-1:0] req_addr = 18'h0;
  logic [1:0]         req_byte_en = 2'h0;
  logic [`DATA_W-1:0] req_wdata = 16'h0;
  logic [3:0]         pins;
  wire                req_ready, rsp_valid, chip_select_n, write_strobe_n;
  wire                output_enable_n, low_byte_enable_n, high_byte_enable_n, data_bus_oe;
  wire [`DATA_W-1:0]  rsp_rdata, data_bus_in, data_bus_out;
  wire [`ADDR_W-1:0]  word_address;
  int                 errors = 0;
  int                 num_checks = 0;
  initial forever #25 clk = ~clk;
  sram_host_ctl dut_u (.clk, .rst, .req_valid, .req_write, .req_addr, .req_byte_en,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n,
    .write_strobe_n, .output_enable_n, .low_byte_enable_n, .high_byte_enable_n,
    .data_bus_in, .data_bus_out, .data_bus_oe);
  sram_model mem_u (.clk, .word_address, .chip_select_n, .write_strobe_n,
    .output_enable_n, .low_byte_enable_n, .high_byte_enable_n, .data_bus_out,
    .data_bus_oe, .data_bus_in);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [17:0] a, input logic [1:0] be,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_byte_en, req_wdata} = {1'b1, w, a, be, d};
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        end_sim;
      end
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n <= 20) begin
      @(negedge clk);
      n++;
      if (n == 2)
        pins = {high_byte_enable_n, low_byte_enable_n, write_strobe_n, output_enable_n};
    end
    chk(n, 4);
    if (be == 2'h0)
      chk(pins[3:2], 2'h3);
    else
      chk(pins, {~be, w ? 2'h1 : 2'h2});
    if (n > 20)
      end_sim;
  endtask
  task automatic t_word;
    xfer(1'b1, 18'h3ffff, 2'h3, 16'ha55a);
    xfer(1'b1, 18'h00000, 2'h3, 16'h1234);
    xfer(1'b0, 18'h3ffff, 2'h3, 16'h0000);
    chk(rsp_rdata, 16'ha55a);
    xfer(1'b0, 18'h00000, 2'h3, 16'h0000);
    chk(rsp_rdata, 16'h1234);
    $display("t_word done");
  endtask
  task automatic t_bytes;
    xfer(1'b1, 18'h00155, 2'h3, 16'h0000);
    xfer(1'b1, 18'h00155, 2'h1, 16'hff11);
    xfer(1'b1, 18'h00155, 2'h2, 16'h22ee);
    xfer(1'b0, 18'h00155, 2'h3, 16'h0000);
    chk(rsp_rdata, 16'h2211);
    xfer(1'b0, 18'h00155, 2'h1, 16'h0000);
    chk(rsp_rdata, 16'h0011);
    xfer(1'b0, 18'h00155, 2'h2, 16'h0000);
    chk(rsp_rdata, 16'h2200);
    $display("t_bytes done");
  endtask
  task automatic t_none;
    xfer(1'b1, 18'h00155, 2'h0, 16'hffff);
    xfer(1'b0, 18'h00155, 2'h0, 16'h0000);
    chk(rsp_rdata, 16'h0000);
    xfer(1'b0, 18'h00155, 2'h3, 16'h0000);
    chk(rsp_rdata, 16'h2211);
    $display("t_none done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    chk({chip_select_n, write_strobe_n, output_enable_n, data_bus_oe}, 4'he);
    rst = 1'b0;
    t_word;
    t_bytes;
    t_none;
    end_sim;
  end
endmodule // tb
bind sram_host_ctl sram_ctl_chk chk_u (.clk, .rst, .req_valid, .req_ready, .rsp_valid,
  .word_address, .chip_select_n, .write_strobe_n, .output_enable_n, .data_bus_out,
  .data_bus_oe);
